// File: port_irq_ctrl.sv
// Purpose: port pin edge interrupt control with wishbone registers
// Assumes: classic wishbone, one-cycle ack, 8-bit data in bits 7:0
// Notes:   request outputs are per-port levels of enabled pending flags
`include "port_irq_cfg.svh"
module port_irq_ctrl (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire port_irq_pkg::byte_t port0_pin_i,
    input  wire port_irq_pkg::byte_t port1_pin_i,
    input  wire port_irq_pkg::p2_t   port2_pin_i,
    output logic                     port0_irq_o,
    output logic                     port1_irq_o,
    output logic                     port2_irq_o
);
    import port_irq_pkg::*;

    byte_t port_interrupt_control_reg;
    byte_t port0_pending_flags_reg;
    byte_t port1_pending_flags_reg;
    p2_t   port2_pending_flags_reg;
    byte_t port1_pin_irq_mask_reg;
    logic  ack_reg;
    byte_t p0_pulse;
    byte_t p1_pulse;
    p2_t   p2_pulse;
    byte_t rdata;
    logic  req;
    logic  wr;
    logic  port2_group_irq_enable;
    logic  port0_upper_irq_enable;
    logic  port0_lower_irq_enable;
    logic  port2_edge_select;
    logic  port1_edge_select;
    logic  port0_edge_select;
    byte_t p0_en;

    assign req = wb_cyc_i & wb_stb_i;
    // write lands on the ack edge
    assign wr  = req & wb_we_i & wb_sel_i[0] & ack_reg;

    assign port2_group_irq_enable =
        port_interrupt_control_reg[`BIT_P2_EN];
    assign port0_upper_irq_enable =
        port_interrupt_control_reg[`BIT_P0H_EN];
    assign port0_lower_irq_enable =
        port_interrupt_control_reg[`BIT_P0L_EN];
    assign port2_edge_select = port_interrupt_control_reg[`BIT_P2_EDGE];
    assign port1_edge_select = port_interrupt_control_reg[`BIT_P1_EDGE];
    // RULE_07 usb resume relies on rising
    assign port0_edge_select = port_interrupt_control_reg[`BIT_P0_EDGE];

    // RULE_06 port 0 edge
    edge_detect #(.W(8)) u_p0 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .pin_i     (port0_pin_i),
        .falling_i (port0_edge_select),
        .pulse_o   (p0_pulse)
    );
    // RULE_05 port 1 edge
    edge_detect #(.W(8)) u_p1 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .pin_i     (port1_pin_i),
        .falling_i (port1_edge_select),
        .pulse_o   (p1_pulse)
    );
    // RULE_04 port 2 edge
    edge_detect #(.W(5)) u_p2 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .pin_i     (port2_pin_i),
        .falling_i (port2_edge_select),
        .pulse_o   (p2_pulse)
    );

    // bus ack, one cycle per request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end
    assign wb_ack_o = ack_reg;

    // control register, bit 7 read-only zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_interrupt_control_reg <= `CTRL_RESET;
        end else if (wr && wb_adr_i == `CTRL_OFFSET) begin
            port_interrupt_control_reg <= wb_dat_i[7:0] & `CTRL_WMASK;
        end
    end

    // RULE_09 port 1 mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port1_pin_irq_mask_reg <= `MASK_RESET;
        end else if (wr && wb_adr_i == `P1_MASK_OFFSET) begin
            port1_pin_irq_mask_reg <= wb_dat_i[7:0];
        end
    end

    // RULE_08 pending flags, set wins over write-zero clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port0_pending_flags_reg <= `FLAG_RESET;
            port1_pending_flags_reg <= `FLAG_RESET;
            port2_pending_flags_reg <= `P2_FLAG_RESET;
        end else begin
            port0_pending_flags_reg <= ((wr && wb_adr_i == `P0_FLAG_OFFSET)
                ? (port0_pending_flags_reg & wb_dat_i[7:0])
                : port0_pending_flags_reg) | p0_pulse;
            port1_pending_flags_reg <= ((wr && wb_adr_i == `P1_FLAG_OFFSET)
                ? (port1_pending_flags_reg & wb_dat_i[7:0])
                : port1_pending_flags_reg) | p1_pulse;
            port2_pending_flags_reg <= ((wr && wb_adr_i == `P2_FLAG_OFFSET)
                ? (port2_pending_flags_reg & wb_dat_i[4:0])
                : port2_pending_flags_reg) | p2_pulse;
        end
    end

    // RULE_02 upper nibble gate
    // RULE_03 lower nibble gate
    assign p0_en = {{4{port0_upper_irq_enable}}, {4{port0_lower_irq_enable}}};
    assign port0_irq_o = |(port0_pending_flags_reg & p0_en);
    // RULE_09 per-pin mask gate
    assign port1_irq_o = |(port1_pending_flags_reg & port1_pin_irq_mask_reg);
    // RULE_01 port 2 group gate
    assign port2_irq_o = port2_group_irq_enable & (|port2_pending_flags_reg);

    // read mux, unmapped reads zero
    always_comb begin
        unique case (wb_adr_i)
            `CTRL_OFFSET:    rdata = port_interrupt_control_reg;
            `P0_FLAG_OFFSET: rdata = port0_pending_flags_reg;
            `P1_FLAG_OFFSET: rdata = port1_pending_flags_reg;
            `P2_FLAG_OFFSET: rdata = {3'h0, port2_pending_flags_reg};
            `P1_MASK_OFFSET: rdata = port1_pin_irq_mask_reg;
            default:         rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else begin
            wb_dat_o <= {24'h0, rdata};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_p2_gate_off: assert property (!port2_group_irq_enable |-> !port2_irq_o) // RULE_01
        else $error("port 2 request while disabled");
    a_p2_gate_on: assert property ( // RULE_01
        (port2_group_irq_enable && |port2_pending_flags_reg) |-> port2_irq_o)
        else $error("port 2 request not passed");
    a_p0_both_off: assert property ( // RULE_02
        (!port0_upper_irq_enable && !port0_lower_irq_enable) |-> !port0_irq_o)
        else $error("port 0 request while disabled");
    a_p0_upper_gate: assert property ( // RULE_02
        (!port0_lower_irq_enable && |port0_pending_flags_reg[7:4])
            |-> (port0_irq_o == port0_upper_irq_enable))
        else $error("port 0 upper gating wrong");
    a_p0_lower_gate: assert property ( // RULE_03
        (!port0_upper_irq_enable && |port0_pending_flags_reg[3:0])
            |-> (port0_irq_o == port0_lower_irq_enable))
        else $error("port 0 lower gating wrong");
    a_p2_edge_set: assert property (p2_pulse[0] |=> port2_pending_flags_reg[0]) // RULE_04
        else $error("port 2 edge not flagged");
    a_p2_edge_fall: assert property ( // RULE_04
        (port2_edge_select && u_p2.primed_reg[2]
            && $fell(u_p2.sync_reg[0]))
            |=> port2_pending_flags_reg[0])
        else $error("port 2 falling edge missed");
    a_p1_edge_rise: assert property ( // RULE_05
        (!port1_edge_select && u_p1.primed_reg[2]
            && $rose(u_p1.sync_reg[0]))
            |=> port1_pending_flags_reg[0])
        else $error("port 1 rising edge missed");
    a_p0_edge_fall: assert property ( // RULE_06
        (port0_edge_select && u_p0.primed_reg[2]
            && $fell(u_p0.sync_reg[0]))
            |=> port0_pending_flags_reg[0])
        else $error("port 0 falling edge missed");
    a_flag_hold: assert property ( // RULE_08
        (port1_pending_flags_reg[0] && !wr) |=> port1_pending_flags_reg[0])
        else $error("pending flag lost");
    a_flag_clear: assert property ( // RULE_08
        (wr && wb_adr_i == `P1_FLAG_OFFSET && !wb_dat_i[0] && !p1_pulse[0])
            |=> !port1_pending_flags_reg[0])
        else $error("pending flag not cleared");
    a_p1_mask_gate: assert property ( // RULE_09
        (port1_pin_irq_mask_reg == 8'h00) |-> !port1_irq_o)
        else $error("port 1 request while masked");
    a_p1_mask_pass: assert property ( // RULE_09
        ((port1_pending_flags_reg & port1_pin_irq_mask_reg) != 8'h00)
            |-> port1_irq_o)
        else $error("port 1 request not passed");
    a_pulse_single: assert property (p0_pulse[0] |=> !p0_pulse[0]) // RULE_10
        else $error("edge pulse longer than one cycle");
    a_no_early_edge: assert property ( // RULE_10
        !u_p0.primed_reg[2] |-> (p0_pulse == 8'h00))
        else $error("edge pulse before history filled");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_read_ctrl: assert property (
        (wb_ack_o && !wb_we_i && wb_adr_i == `CTRL_OFFSET)
            |-> (wb_dat_o[7:0] == port_interrupt_control_reg))
        else $error("control read data wrong");

    c_p0_irq: cover property (port0_irq_o);
    c_p1_irq: cover property (port1_irq_o);
    c_p2_irq: cover property (port2_irq_o);
    c_flag_clear: cover property (wr && wb_adr_i == `P0_FLAG_OFFSET);
    c_p1_fall: cover property (port1_edge_select && |p1_pulse);
endmodule : port_irq_ctrl

// File: port_irq_cfg.svh
// Purpose: constants for the port pin interrupt control block
// Assumes: wishbone word addressing, 8-bit registers in low data bits
// Notes:   offsets are word addresses on the register bus
// Summary of operation
// RULE_01: control bit 5 gates requests from port 2 pins four to zero.
// RULE_02: control bit 4 enables requests from port 0 pins seven to four.
// RULE_03: control bit 3 enables requests from port 0 pins three to zero.
// RULE_04: control bit 2 picks port 2 edge: 0 rising, 1 falling.
// RULE_05: control bit 1 picks port 1 edge: 0 rising, 1 falling.
// RULE_06: control bit 0 picks port 0 edge: 0 rising, 1 falling.
// RULE_07: software keeps port 0 edge rising while usb resume is used.
// RULE_08: each pin has a pending flag; software clears by writing 0.
// RULE_09: port 1 pins have individual enables in a mask register.
// RULE_10: pins synchronised, compared with last sample; one-cycle pulse.
`ifndef PORT_IRQ_CFG_SVH
`define PORT_IRQ_CFG_SVH
`define CTRL_OFFSET     8'h8c
`define P0_FLAG_OFFSET  8'h89
`define P1_FLAG_OFFSET  8'h8a
`define P2_FLAG_OFFSET  8'h8b
`define P1_MASK_OFFSET  8'h8d
`define CTRL_RESET      8'h00
`define FLAG_RESET      8'h00
`define P2_FLAG_RESET   5'h00
`define MASK_RESET      8'h00
`define CTRL_WMASK      8'h7f
`define BIT_P2_EN       5
`define BIT_P0H_EN      4
`define BIT_P0L_EN      3
`define BIT_P2_EDGE     2
`define BIT_P1_EDGE     1
`define BIT_P0_EDGE     0
`endif

// File: port_irq_pkg.sv
// Purpose: shared types for the port pin interrupt block
// Assumes: nothing
// Notes:   widths fixed
package port_irq_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [4:0] p2_t;
endpackage : port_irq_pkg

// File: edge_detect.sv
// Purpose: synchronise a group of pins and pulse on the chosen edge
// Assumes: pins asynchronous to clk_i
// Notes:   one instance per port
module edge_detect #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    input  wire logic         falling_i,
    output logic      [W-1:0] pulse_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;
    logic [2:0]   primed_reg;

    // RULE_10 two-stage sync, history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // no pulses until history holds real pin samples
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            primed_reg <= 3'h0;
        end else begin
            primed_reg <= {primed_reg[1:0], 1'b1};
        end
    end

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // RULE_10 edge compare
            assign pulse_o[g] = primed_reg[2] &
                (falling_i ? (prev_reg[g] & ~sync_reg[g])
                           : (~prev_reg[g] & sync_reg[g]));
        end
    endgenerate
endmodule : edge_detect

// File: pin_source.sv
// Purpose: model of external signals on the port input pins
// Assumes: pin levels change only just after a clock edge
// Notes:   levels are held until the bench commands new ones
module pin_source (
    input  wire logic        clk_i,
    input  wire logic [20:0] lvl_i,
    output logic      [7:0]  p0_o,
    output logic      [7:0]  p1_o,
    output logic      [4:0]  p2_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk_i) begin
        {p2_o, p1_o, p0_o} <= lvl_i;
    end
endmodule : pin_source

// File: port_irq_ctrl_test.sv
// Purpose: self-checking bench for port pin interrupt control
// Assumes: wishbone ack one cycle after request, flags settle in 8 cycles
// Notes:   read data is checked against a queue of expectations
module port_irq_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    import port_irq_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [3:0]  sel   = 4'h0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0;
    logic [20:0] lvl   = 21'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [20:0] r;
    logic [20:0] idle;
    logic [7:0]  edg;
    byte_t       p0;
    byte_t       p1;
    p2_t         p2;
    logic        irq0;
    logic        irq1;
    logic        irq2;
    logic [31:0] exp_q[$];
    int          err_total = 0;
    int          n_tests   = 0;

    always #50 clk_i = ~clk_i;

    pin_source src (.clk_i(clk_i), .lvl_i(lvl), .p0_o(p0), .p1_o(p1),
                    .p2_o(p2));
    port_irq_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .port0_pin_i(p0), .port1_pin_i(p1), .port2_pin_i(p2),
        .port0_irq_o(irq0), .port1_irq_o(irq1), .port2_irq_o(irq2));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, {24'h0, d}, 4'h1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        wb(1'b0, a, 32'h0, 4'h1);
    endtask : rd

    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // read data taken at the ack edge
    always @(posedge clk_i) begin
        if (ack === 1'b1 && !we && exp_q.size() > 0) begin
            check(rdat, exp_q.pop_front());
        end
    end

    initial begin
        #(100 * 20000);
        err_total++;
        finish_test();
    end

    initial begin
        void'($urandom(81));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h8c, 8'h00);
        wr(8'h8c, 8'hff);
        rd(8'h8c, 8'h7f);
        wb(1'b1, 8'h8c, 32'h0, 4'h0);
        rd(8'h8c, 8'h7f);
        rd(8'h80, 8'h00);
        $display("register access test done");
        for (int i = 0; i < 4; i++) begin
            idle = i[0] ? 21'h1fffff : 21'h0;
            edg  = i[0] ? 8'h07 : 8'h00;
            wr(8'h8c, 8'h38 | edg);
            wr(8'h8d, 8'hff);
            lvl <= idle;
            repeat (8) @(posedge clk_i);
            for (int a = 0; a < 3; a++) wr(8'h89 + 8'(a), 8'h00);
            r = 21'($urandom);
            lvl <= idle ^ r;
            repeat (8) @(posedge clk_i);
            rd(8'h89, r[7:0]);
            rd(8'h8a, r[15:8]);
            rd(8'h8b, {3'h0, r[20:16]});
            check(32'(irq1), 32'(|r[15:8]));
            wr(8'h8c, 8'h10 | edg);
            check(32'(irq0), 32'(|r[7:4]));
            check(32'(irq2), 32'h0);
            wr(8'h8c, 8'h08 | edg);
            check(32'(irq0), 32'(|r[3:0]));
            wr(8'h8c, 8'h20 | edg);
            check(32'(irq2), 32'(|r[20:16]));
            check(32'(irq0), 32'h0);
            wr(8'h8d, 8'h0f);
            check(32'(irq1), 32'(|r[11:8]));
            wr(8'h89, 8'hff);
            rd(8'h89, r[7:0]);
            for (int a = 0; a < 3; a++) wr(8'h89 + 8'(a), 8'h00);
            lvl <= idle;
            repeat (8) @(posedge clk_i);
            for (int a = 0; a < 3; a++) rd(8'h89 + 8'(a), 8'h00);
            $display("edge test %0d done", i);
        end
        repeat (2) @(posedge clk_i);
        finish_test();
    end
endmodule : port_irq_ctrl_test
